// ==== design/pin_mux_defs.vh ====
/*
 Constants for the clock output and port A pin mux.
 Assumes inclusion by bare name from design/pin_mux.v.
*/
// Overview of operation
// R1: Clock output pin drives a buffered clock, disabled while reset is held.
// R2: Select value routes none, master, bus, oscillator, prescaler, postscaler.
// R3: External clock drives crystal drive pin; crystal return pin is grounded.
// R4: Oscillator clock either feeds the core directly or is the PLL reference.
// R5: Idle external bus tri-states address 8 to 13 and controls per hold bit.
// R6: After reset the six shared pins carry the address function.
// R7: Each port A line is independently input or output in port mode.
// R8: Clearing pull-up enable bit n turns off the pull-up on line n.
// R9: In this package software uses the shared pins only as port lines.
// R10: Clock input select 1 takes external clock, 0 uses crystal oscillator.
// R11: Port A pull-up enables reset to all ones.
`ifndef PIN_MUX_DEFS_VH
`define PIN_MUX_DEFS_VH
`define CLK_OUT_SEL_W      3
`define CLK_OUT_SEL_OFF    3'h0
`define CLK_OUT_SEL_MASTER 3'h1
`define CLK_OUT_SEL_BUS    3'h2
`define CLK_OUT_SEL_OSC    3'h3
`define CLK_OUT_SEL_PRE    3'h4
`define CLK_OUT_SEL_POST   3'h5
`define CLK_OUT_SEL_RESET  3'h0
`define PORT_A_W        6
`define PULLUP_RESET    6'h3F
`define DIR_RESET       6'h00
`define FUNC_RESET      6'h3F
`define DATA_RESET      6'h00
`endif

// ==== design/pin_mux.v ====
/*
 Pin mux for the clock output, oscillator pins and port A shared pins.
 Assumes all control inputs are synchronous to core_clk; clock sources
 arrive as plain signals and are gated combinationally onto the pin.
*/
`timescale 1ns/1ps
`include "pin_mux_defs.vh"
module pin_mux (
    input  wire        core_clk,
    input  wire        sys_rst,
    input  wire        clk_en,
    input  wire        clock_input_select,
    input  wire        crystal_drive_in,
    input  wire        crystal_osc_clk,
    input  wire        pll_select,
    input  wire        pll_out_clk,
    input  wire        master_system_clock,
    input  wire        peripheral_bus_clock,
    input  wire        prescaler_clock,
    input  wire        postscaler_clock,
    input  wire        cfg_we,
    input  wire [2:0]  clock_out_select_in,
    input  wire [5:0]  port_a_func_in,
    input  wire [5:0]  port_a_dir_in,
    input  wire [5:0]  port_a_data_in,
    input  wire [5:0]  port_a_pullup_in,
    input  wire        bus_drive_hold_bit,
    input  wire        ext_bus_active,
    input  wire [5:0]  ext_mem_addr,
    input  wire [5:0]  pin_in,
    output wire [5:0]  pin_out,
    output wire [5:0]  pin_oe_n,
    output wire [5:0]  pin_pullup,
    output reg  [5:0]  port_a_read,
    output wire        ext_mem_ctrl_tristate,
    output wire        osc_ref_clk,
    output wire        core_src_clk,
    output wire        buffered_clock_out_pin,
    output wire        buffered_clock_out_oe_n,
    output reg  [2:0]  clock_out_select_reg,
    output reg  [5:0]  port_a_pullup_enables
);
    reg  [5:0] port_a_func;
    reg  [5:0] port_a_dir;
    reg  [5:0] port_a_data;
    reg  [2:0] next_clock_out_select;
    reg  [5:0] next_port_a_func;
    reg  [5:0] next_port_a_dir;
    reg  [5:0] next_port_a_data;
    reg  [5:0] next_port_a_pullup;
    reg  [5:0] next_port_a_read;
    reg        clk_out_mux;
    wire       load_cfg;
    wire       clk_out_on;
    wire       addr_drive;
    genvar     i;

    // Only codes one to five name a source; the rest leave the pin off.
    function clk_out_src_valid;
        input [2:0] sel;
        begin
            case (sel)
                `CLK_OUT_SEL_MASTER,
                `CLK_OUT_SEL_BUS,
                `CLK_OUT_SEL_OSC,
                `CLK_OUT_SEL_PRE,
                `CLK_OUT_SEL_POST: begin
                    clk_out_src_valid = 1'b1;
                end
                default: begin
                    clk_out_src_valid = 1'b0;
                end
            endcase
        end
    endfunction

    // A pin is released in reset, else set by its function and direction.
    function pin_enable_n;
        input in_reset;
        input addr_func;
        input out_dir;
        input drive_addr;
        begin
            if (in_reset) begin
                pin_enable_n = 1'b1;
            end else if (addr_func) begin
                pin_enable_n = !drive_addr;
            end else begin
                pin_enable_n = !out_dir;
            end
        end
    endfunction

    // A shared pin carries its address bit or its port data bit.
    function pin_level;
        input addr_func;
        input addr_bit;
        input data_bit;
        begin
            if (addr_func) begin
                pin_level = addr_bit;
            end else begin
                pin_level = data_bit;
            end
        end
    endfunction

    // A write is taken only while the clock enable is high.
    assign load_cfg = clk_en && cfg_we;

    always @* begin
        next_clock_out_select = clock_out_select_reg;
        next_port_a_func      = port_a_func;
        next_port_a_dir       = port_a_dir;
        next_port_a_data      = port_a_data;
        next_port_a_pullup    = port_a_pullup_enables;
        if (load_cfg) begin
            next_clock_out_select = clock_out_select_in; // R2
            next_port_a_func      = port_a_func_in;
            next_port_a_dir       = port_a_dir_in; // R7
            next_port_a_data      = port_a_data_in;
            next_port_a_pullup    = port_a_pullup_in; // R8
        end
    end

    // Pad levels are sampled on every enabled cycle.
    always @* begin
        next_port_a_read = port_a_read;
        if (clk_en) begin
            next_port_a_read = pin_in; // R7
        end
    end

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            clock_out_select_reg <= `CLK_OUT_SEL_RESET;
        end else begin
            clock_out_select_reg <= next_clock_out_select;
        end
    end

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            port_a_func <= `FUNC_RESET; // R6
        end else begin
            port_a_func <= next_port_a_func;
        end
    end

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            port_a_dir <= `DIR_RESET;
        end else begin
            port_a_dir <= next_port_a_dir;
        end
    end

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            port_a_data <= `DATA_RESET;
        end else begin
            port_a_data <= next_port_a_data;
        end
    end

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            port_a_pullup_enables <= `PULLUP_RESET; // R11
        end else begin
            port_a_pullup_enables <= next_port_a_pullup;
        end
    end

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            port_a_read <= `DATA_RESET;
        end else begin
            port_a_read <= next_port_a_read;
        end
    end

    // Oscillator clock is the external pin or the crystal oscillator.
    assign osc_ref_clk  = clock_input_select ? crystal_drive_in
                                             : crystal_osc_clk; // R10
    assign core_src_clk = pll_select ? pll_out_clk : osc_ref_clk; // R4

    always @* begin
        case (clock_out_select_reg)
            `CLK_OUT_SEL_MASTER: begin
                clk_out_mux = master_system_clock; // R2
            end
            `CLK_OUT_SEL_BUS: begin
                clk_out_mux = peripheral_bus_clock;
            end
            `CLK_OUT_SEL_OSC: begin
                clk_out_mux = osc_ref_clk;
            end
            `CLK_OUT_SEL_PRE: begin
                clk_out_mux = prescaler_clock;
            end
            `CLK_OUT_SEL_POST: begin
                clk_out_mux = postscaler_clock;
            end
            default: begin
                clk_out_mux = 1'b0;
            end
        endcase
    end

    assign clk_out_on = !sys_rst &&
                        clk_out_src_valid(clock_out_select_reg); // R1
    assign buffered_clock_out_pin  = clk_out_on ? clk_out_mux : 1'b0; // R1
    assign buffered_clock_out_oe_n = !clk_out_on; // R1

    // Address lines are driven while the bus is busy or the hold bit is set.
    assign addr_drive = !sys_rst && (ext_bus_active || bus_drive_hold_bit);
    assign ext_mem_ctrl_tristate = !addr_drive; // R5

    generate
        for (i = 0; i < `PORT_A_W; i = i + 1) begin : g_pin
            assign pin_out[i] = pin_level(port_a_func[i], ext_mem_addr[i],
                                          port_a_data[i]);
            assign pin_oe_n[i] = pin_enable_n(sys_rst, port_a_func[i],
                                              port_a_dir[i],
                                              addr_drive); // R5
            assign pin_pullup[i] = port_a_pullup_enables[i]; // R8
        end
    endgenerate
endmodule // pin_mux

// ==== bench/pin_mux_chk.sv ====
/* Port checker for pin_mux. Assumes it is bound to every pin_mux. */
`timescale 1ns/1ps
module pin_mux_chk (
    input logic core_clk, sys_rst, buffered_clock_out_oe_n,
    input logic buffered_clock_out_pin, master_system_clock,
    input logic peripheral_bus_clock, clock_input_select,
    input logic crystal_drive_in, pll_select, osc_ref_clk, core_src_clk,
    input logic ext_bus_active, bus_drive_hold_bit, ext_mem_ctrl_tristate,
    input logic [2:0] clock_out_select_reg,
    input logic [5:0] pin_pullup, port_a_pullup_enables
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    a_rst_clk_off: assert property (disable iff (1'b0) sys_rst |->
        buffered_clock_out_oe_n && !buffered_clock_out_pin)
        else $error("clock out on at reset");
    a_sel_spare: assert property (clock_out_select_reg >= 3'h6 |->
        buffered_clock_out_oe_n) else $error("spare select drives pin");
    a_rst_pullups: assert property ($fell(sys_rst) |->
        port_a_pullup_enables == 6'h3F) else $error("pullups not set");
    a_sel_master: assert property (clock_out_select_reg == 3'h1 |->
        buffered_clock_out_pin == master_system_clock) else $error("sel1");
    a_sel_bus: assert property (clock_out_select_reg == 3'h2 |->
        buffered_clock_out_pin == peripheral_bus_clock) else $error("sel2");
    a_sel_off: assert property (clock_out_select_reg == 3'h0 |->
        !buffered_clock_out_pin) else $error("clock out not off");
    a_ext_clock: assert property (clock_input_select |->
        osc_ref_clk == crystal_drive_in) else $error("osc mode");
    a_core_direct: assert property (!pll_select |->
        core_src_clk == osc_ref_clk) else $error("core clock");
    a_idle_tristate: assert property (!ext_bus_active &&
        !bus_drive_hold_bit |-> ext_mem_ctrl_tristate) else $error("ctrl");
    a_pullup_map: assert property (pin_pullup ==
        port_a_pullup_enables) else $error("pullup map");
endmodule // pin_mux_chk
bind pin_mux pin_mux_chk i_pin_mux_chk (.*);

// ==== bench/pad_model.sv ====
/* Pads of port A. Assumes the bench gives the external drive. */
`timescale 1ns/1ps
module pad_model (
    input logic core_clk,
    input logic [5:0] pin_out, pin_oe_n, pin_pullup, ext_level, ext_en,
    output logic [5:0] pin_in
);
    logic tgl = 0;
    always @(posedge core_clk) tgl <= ~tgl;
    always @* for (int i = 0; i < 6; i++)
        pin_in[i] = !pin_oe_n[i] ? pin_out[i] : ext_en[i] ? ext_level[i] :
                    pin_pullup[i] ? 1'b1 : tgl;
endmodule // pad_model

// ==== bench/tb.sv ====
/* Bench for pin_mux. Assumes the checker and pad model. */
`timescale 1ns/1ps
module tb;
    logic core_clk=0, sys_rst=1, cfg_we=0, clock_input_select=0,
        crystal_drive_in=0, crystal_osc_clk=0, pll_select=0, pll_out_clk=0,
        master_system_clock=0, peripheral_bus_clock=0, prescaler_clock=0,
        postscaler_clock=0, bus_drive_hold_bit=0, ext_bus_active=1, clk_en=1;
    logic [2:0] clock_out_select_in=0;
    logic [5:0] port_a_func_in=6'h3F, port_a_dir_in=0, port_a_data_in=0,
        port_a_pullup_in=6'h3F, ext_mem_addr=6'h2A, ext_level=0, ext_en=0;
    logic [4:0] p;
    wire [5:0] pin_in, pin_out, pin_oe_n, pin_pullup, port_a_read;
    wire [5:0] port_a_pullup_enables;
    wire [2:0] clock_out_select_reg;
    wire ext_mem_ctrl_tristate, osc_ref_clk, core_src_clk;
    wire buffered_clock_out_pin, buffered_clock_out_oe_n;
    int err_total=0, n_tests=0;
    pin_mux i_pin_mux (.*);
    pad_model i_pad_model (.*);
    initial forever #50 core_clk = ~core_clk;
    task chk(input logic [5:0] s, e);
        n_tests++;
        if (s !== e) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task end_of_test;
        $display("checks=%0d mismatches=%0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task wr(input logic [5:0] f, d, v, u, input logic [2:0] s);
        @(negedge core_clk);
        {port_a_func_in, port_a_dir_in, port_a_data_in} = {f, d, v};
        {port_a_pullup_in, clock_out_select_in, cfg_we} = {u, s, 1'b1};
        @(negedge core_clk);
        cfg_we = 0;
    endtask
    initial begin
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        chk(buffered_clock_out_oe_n, 1);
        chk(port_a_pullup_enables, 6'h3F);
        sys_rst = 0;
        @(negedge core_clk);
        chk(pin_oe_n, 0);
        chk(pin_out, 6'h2A);
        ext_bus_active = 0;
        #1 chk(pin_oe_n, 6'h3F);
        chk(ext_mem_ctrl_tristate, 1);
        @(negedge core_clk);
        bus_drive_hold_bit = 1;
        #1 chk(pin_oe_n, 0);
        $display("bus test done");
        for (int k = 0; k < 8; k++) for (int j = 0; j < 2; j++) begin
            wr(6'h3F, 0, 0, 6'h3F, k[2:0]);
            p = j ? 5'h0A : 5'h15;
            {postscaler_clock, prescaler_clock, crystal_osc_clk} = p[4:2];
            {peripheral_bus_clock, master_system_clock} = p[1:0];
            crystal_drive_in = p[2];
            #1 chk(buffered_clock_out_pin, (k>0 && k<6) ? p[k-1] : 0);
            chk(buffered_clock_out_oe_n, (k>0 && k<6) ? 0 : 1);
        end
        $display("clock out test done");
        wr(0, 6'h05, 6'h3F, 6'h3E, 1);
        {ext_en, ext_level} = {6'h3A, 6'h12};
        repeat (2) @(negedge core_clk);
        chk(pin_oe_n, 6'h3A);
        chk(pin_out & 6'h05, 6'h05);
        chk(pin_pullup, 6'h3E);
        chk(port_a_read, 6'h17);
        ext_level = 6'h00;
        clk_en = 0;
        wr(6'h3F, 0, 0, 6'h3F, 3);
        chk(clock_out_select_reg, 1);
        chk(port_a_pullup_enables, 6'h3E);
        chk(port_a_read, 6'h17);
        clk_en = 1;
        @(negedge core_clk);
        chk(port_a_read, 6'h05);
        $display("clock enable test done");
        {clock_input_select, crystal_drive_in} = 2'b11;
        {crystal_osc_clk, pll_select} = 2'b01;
        #1 chk(osc_ref_clk, 1);
        chk(core_src_clk, 0);
        @(negedge core_clk);
        pll_select = 0;
        #1 chk(core_src_clk, 1);
        $display("port and clock input test done");
        @(negedge core_clk);
        sys_rst = 1;
        #1 chk(pin_oe_n, 6'h3F);
        chk(buffered_clock_out_oe_n, 1);
        @(negedge core_clk);
        chk(port_a_pullup_enables, 6'h3F);
        chk(clock_out_select_reg, 0);
        sys_rst = 0;
        @(negedge core_clk);
        chk(pin_oe_n, 0);
        chk(pin_out, 6'h2A);
        $display("second reset test done");
        end_of_test;
    end
endmodule // tb
